// ===== logic/sptc_device.sv
// Transfer control of the video memory: strobe decode on the system clock,
// serial pointer on the link clock. The array itself sits on the user side
// and acts on the transfer strobe outputs.
`timescale 1ns/100ps
`default_nettype none
module sptc_device
    import sptc_pkg::*;
(
    input  wire logic              MCLK_I,
    input  wire logic              RSTN_I,
    sptc_if.dev                    link,
    input  wire logic              NEW_MASK_MODE_I,
    input  wire logic [DATA_W-1:0] OLD_MASK_I,
    input  wire logic [HALF_W-1:0] STOP_I,
    output logic                   XFER_STB_O,
    output logic                   XFER_WRITE_O,
    output logic                   XFER_LO_O,
    output logic                   XFER_HI_O,
    output logic      [ADDR_W-1:0] XFER_ROW_O,
    output logic      [DATA_W-1:0] XFER_MASK_O,
    output logic                   SER_WRITE_MODE_O,
    output logic                   SC_ACTIVE_O,
    output logic      [ADDR_W-1:0] SER_PTR_O,
    output logic                   SER_LOAD_O
);
    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_XFER = 1'b1
    } sptc_state_e;

    // System clock side
    logic [PIN_W-1:0]  pins_s;
    logic              ras_s, cas_s, toe_s, uwe_s, lwe_s, sfs_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] mask_s;
    logic              ras_p_q, cas_p_q, toe_p_q;
    sptc_state_e       state_q, state_d;
    sptc_kind_e        kind_q, kind_d;
    logic [ADDR_W-1:0] row_q, row_d, tap_q, tap_d;
    logic [DATA_W-1:0] mask_q, mask_d;
    logic              done_q, done_d, mode_q, mode_d;
    logic              stb_q, stb_d, lo_q, lo_d, hi_q, hi_d;
    logic              tgl_q, tgl_d;
    logic [WORD_W-1:0] word_q, word_d;
    logic              half_m, sc_tgl_m, sc_tgl_p_q;
    logic [7:0]        idle_q, idle_d;
    logic              exec;
    logic [7:0]        hold_q, hold_d;
    logic              srq_q, srq_d;

    // Link clock side
    logic              sc_rst_n, ev_s, ev_p_q;
    logic [ADDR_W-1:0] ptr_q, ptr_d;
    logic              armed_q, armed_d, load_q, load_d, sct_q;
    logic [HALF_W-1:0] dest_q, dest_d, stop_q, stop_d;

    sptc_sync #(.W(PIN_W), .RST(PIN_RST)) u_pin_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .d_i     ({link.row_strobe_n, link.col_strobe_n,
                   link.transfer_output_enable_n, link.upper_write_enable_n,
                   link.lower_write_enable_n, link.special_function_select,
                   link.address_pins, link.mask_data_pins}),
        .q_o     (pins_s)
    );
    assign {ras_s, cas_s, toe_s, uwe_s, lwe_s, sfs_s, addr_s, mask_s} = pins_s;

    sptc_sync #(.W(2), .RST(2'h0)) u_back_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .d_i     ({ptr_q[ADDR_W-1], sct_q}),
        .q_o     ({half_m, sc_tgl_m})
    );

    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        row_d   = row_q;
        tap_d   = tap_q;
        mask_d  = mask_q;
        done_d  = done_q;
        mode_d  = mode_q;
        tgl_d   = tgl_q;
        word_d  = word_q;
        stb_d   = 1'b0;
        lo_d    = lo_q;
        hi_d    = hi_q;
        exec    = 1'b0;
        // Activity of the serial clock seen as a toggle within the window
        idle_d  = (sc_tgl_m != sc_tgl_p_q) ? 8'h00 :
                  (idle_q == 8'(SC_IDLE_CYC)) ? idle_q : idle_q + 8'h01;
        // Serial side reset request outlives the system reset
        hold_d  = (hold_q == 8'(2 * SC_IDLE_CYC)) ? hold_q : hold_q + 8'h01;
        srq_d   = hold_q == 8'(2 * SC_IDLE_CYC);
        case (state_q)
            S_IDLE: begin
                if (ras_p_q && !ras_s && cas_s && !toe_s) begin
                    kind_d  = sptc_decode(uwe_s & lwe_s, sfs_s);
                    row_d   = addr_s;
                    // Masking always applies to write transfers
                    mask_d  = NEW_MASK_MODE_I ? mask_s : OLD_MASK_I;
                    done_d  = 1'b0;
                    state_d = S_XFER;
                end
            end
            S_XFER: begin
                if (cas_p_q && !cas_s) begin
                    tap_d = kind_q[0] ? {1'b0, addr_s[HALF_W-1:0]}
                                      : addr_s;
                end
                if (kind_q == K_SINGLE_RD && !done_q && !toe_p_q && toe_s &&
                    SC_ACTIVE_O) begin
                    exec   = 1'b1;
                    done_d = 1'b1;
                end
                if (!ras_p_q && ras_s) begin
                    exec    = !done_q;
                    if (kind_q == K_SINGLE_RD) begin
                        mode_d = 1'b0;
                    end
                    if (kind_q == K_SINGLE_WR) begin
                        mode_d = 1'b1;
                    end
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (exec) begin
            stb_d  = 1'b1;
            // Split moves only the half the pointer is not in
            lo_d   = !kind_q[0] || half_m;
            hi_d   = !kind_q[0] || !half_m;
            tgl_d  = ~tgl_q;
            word_d = {kind_q[0], tap_d, STOP_I};
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            ras_p_q    <= 1'b1;
            cas_p_q    <= 1'b1;
            toe_p_q    <= 1'b1;
            state_q    <= S_IDLE;
            kind_q     <= K_SINGLE_RD;
            row_q      <= '0;
            tap_q      <= '0;
            mask_q     <= '0;
            done_q     <= 1'b0;
            mode_q     <= SER_MODE_RST;
            stb_q      <= 1'b0;
            lo_q       <= 1'b0;
            hi_q       <= 1'b0;
            tgl_q      <= 1'b0;
            word_q     <= {1'b0, 9'h000, STOP_RST};
            sc_tgl_p_q <= 1'b0;
            idle_q     <= 8'(SC_IDLE_CYC);
            hold_q     <= 8'h00;
            srq_q      <= 1'b0;
        end else begin
            ras_p_q    <= ras_s;
            cas_p_q    <= cas_s;
            toe_p_q    <= toe_s;
            state_q    <= state_d;
            kind_q     <= kind_d;
            row_q      <= row_d;
            tap_q      <= tap_d;
            mask_q     <= mask_d;
            done_q     <= done_d;
            mode_q     <= mode_d;
            stb_q      <= stb_d;
            lo_q       <= lo_d;
            hi_q       <= hi_d;
            tgl_q      <= tgl_d;
            word_q     <= word_d;
            sc_tgl_p_q <= sc_tgl_m;
            idle_q     <= idle_d;
            hold_q     <= hold_d;
            srq_q      <= srq_d;
        end
    end

    assign SC_ACTIVE_O      = idle_q != 8'(SC_IDLE_CYC);
    assign XFER_STB_O       = stb_q;
    assign XFER_WRITE_O     = kind_q[1];
    assign XFER_LO_O        = lo_q;
    assign XFER_HI_O        = hi_q;
    assign XFER_ROW_O       = row_q;
    assign XFER_MASK_O      = mask_q;
    assign SER_WRITE_MODE_O = mode_q;

    // The serial clock may stop, even in reset; its reset only takes hold
    // while it runs, so the request is stretched over eight of its periods
    sptc_sync #(.W(1), .RST(1'b0)) u_rst_sync (
        .clk_i   (link.serial_clock),
        .rst_n_i (1'b1),
        .d_i     (srq_q),
        .q_o     (sc_rst_n)
    );

    // Word is held from its toggle until the next transfer, so it is stable
    sptc_sync #(.W(1), .RST(1'b0)) u_ev_sync (
        .clk_i   (link.serial_clock),
        .rst_n_i (sc_rst_n),
        .d_i     (tgl_q),
        .q_o     (ev_s)
    );

    always_comb begin
        ptr_d   = ptr_q + 9'h001;
        armed_d = armed_q;
        dest_d  = dest_q;
        stop_d  = stop_q;
        load_d  = 1'b0;
        if (ev_s != ev_p_q) begin
            if (!word_q[WORD_W-1]) begin
                // A load wins over the count on the same edge
                ptr_d   = word_q[HALF_W +: ADDR_W];
                armed_d = 1'b0;
                load_d  = 1'b1;
            end else begin
                // Serial side carries on in its own half meanwhile
                armed_d = 1'b1;
                dest_d  = word_q[HALF_W +: HALF_W];
                stop_d  = word_q[HALF_W-1:0];
            end
        end else if (armed_q && sptc_is_jump(ptr_q, stop_q)) begin
            ptr_d   = {~ptr_q[ADDR_W-1], dest_q};
            armed_d = 1'b0;
        end
    end

    always_ff @(posedge link.serial_clock) begin
        if (!sc_rst_n) begin
            ev_p_q  <= 1'b0;
            ptr_q   <= '0;
            armed_q <= 1'b0;
            dest_q  <= '0;
            stop_q  <= STOP_RST;
            load_q  <= 1'b0;
            sct_q   <= 1'b0;
        end else begin
            ev_p_q  <= ev_s;
            ptr_q   <= ptr_d;
            armed_q <= armed_d;
            dest_q  <= dest_d;
            stop_q  <= stop_d;
            load_q  <= load_d;
            sct_q   <= ~sct_q;
        end
    end

    assign link.half_indicator = ptr_q[ADDR_W-1];
    assign SER_PTR_O           = ptr_q;
    assign SER_LOAD_O          = load_q;
endmodule // sptc_device
`default_nettype wire

// ===== logic/sptc_pkg.sv
// Shared constants, types and decode functions of the serial transfer block.
// Assumes a 100 MHz system clock and a link (serial) clock of 80 ns period.
package sptc_pkg;
    localparam int ADDR_W   = 9;
    localparam int DATA_W   = 16;
    localparam int HALF_W   = 8;
    localparam int PIN_W    = 6 + ADDR_W + DATA_W;
    localparam int WORD_W   = 1 + ADDR_W + HALF_W;

    localparam int CLK_PERIOD_NS  = 10;
    localparam int LINK_PERIOD_NS = 80;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int SC_IDLE_NS     = 320;
    localparam int SC_IDLE_CYC    = SC_IDLE_NS / CLK_PERIOD_NS;
    localparam int STEP_NS        = 40;
    localparam int STEP_CYC       =
        (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [PIN_W-1:0]  PIN_RST      = 31'h7E00_0000;
    localparam logic [HALF_W-1:0] STOP_RST     = 8'hFF;
    localparam logic              SER_MODE_RST = 1'b1;

    typedef enum logic [1:0] {
        K_SINGLE_RD = 2'b00,
        K_SPLIT_RD  = 2'b01,
        K_SINGLE_WR = 2'b10,
        K_SPLIT_WR  = 2'b11
    } sptc_kind_e;

    // Bit 1 of the kind is the write direction, bit 0 the split method
    function automatic sptc_kind_e sptc_decode(input logic we_high,
                                               input logic sfs);
        sptc_decode = sptc_kind_e'({~we_high, sfs});
    endfunction

    // Source column: every stop bit that is set is also set in the pointer
    function automatic logic sptc_is_jump(input logic [ADDR_W-1:0] ptr,
                                          input logic [HALF_W-1:0] stop);
        sptc_is_jump = (ptr[HALF_W-1:0] & stop) == stop;
    endfunction
endpackage

// ===== logic/sptc_if.sv
// Pin bundle between the graphics controller and the video memory.
// Assumes the bench joins both modports; all pins are one-way here.
`timescale 1ns/100ps
`default_nettype none
interface sptc_if;
    import sptc_pkg::*;
    logic                row_strobe_n;
    logic                col_strobe_n;
    logic                transfer_output_enable_n;
    logic                upper_write_enable_n;
    logic                lower_write_enable_n;
    logic                special_function_select;
    logic [ADDR_W-1:0]   address_pins;
    logic [DATA_W-1:0]   mask_data_pins;
    logic                serial_clock;
    logic                half_indicator;

    modport ctrl (
        output row_strobe_n, col_strobe_n, transfer_output_enable_n,
        output upper_write_enable_n, lower_write_enable_n,
        output special_function_select, address_pins, mask_data_pins,
        output serial_clock,
        input  half_indicator
    );
    modport dev (
        input  row_strobe_n, col_strobe_n, transfer_output_enable_n,
        input  upper_write_enable_n, lower_write_enable_n,
        input  special_function_select, address_pins, mask_data_pins,
        input  serial_clock,
        output half_indicator
    );
endinterface
`default_nettype wire

// ===== logic/sptc_sync.sv
// Three-stage synchroniser with agreement filter for foreign inputs.
// Assumes the source is held at least three destination clock edges.
`timescale 1ns/100ps
`default_nettype none
module sptc_sync #(
    parameter int              W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, q_d;

    // Only a value seen twice in a row is passed on
    always_comb begin
        q_d = (s2_q == s3_q) ? s3_q : q_o;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q_o  <= RST;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_o  <= q_d;
        end
    end
endmodule // sptc_sync
`default_nettype wire

// ===== logic/sptc_ctrl.sv
// Controller end: plays one transfer cycle per command on the strobes and
// makes the serial clock by dividing the system clock.
`timescale 1ns/100ps
`default_nettype none
module sptc_ctrl
    import sptc_pkg::*;
(
    input  wire logic              MCLK_I,
    input  wire logic              RSTN_I,
    sptc_if.ctrl                   link,
    input  wire logic              CMD_VALID_I,
    output logic                   CMD_READY_O,
    input  wire logic [1:0]        CMD_KIND_I,
    input  wire logic [ADDR_W-1:0] CMD_ROW_I,
    input  wire logic [ADDR_W-1:0] CMD_TAP_I,
    input  wire logic [DATA_W-1:0] CMD_MASK_I,
    input  wire logic              SC_RUN_I,
    output logic                   HALF_O
);
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_RAS  = 3'b001,
        C_CAS  = 3'b010,
        C_TOE  = 3'b011,
        C_UP   = 3'b100
    } sptc_cstate_e;

    sptc_cstate_e      st_q, st_d;
    logic [3:0]        cnt_q, cnt_d;
    logic              ras_q, ras_d, cas_q, cas_d, toe_q, toe_d;
    logic              we_q, we_d, sfs_q, sfs_d;
    logic [ADDR_W-1:0] addr_q, addr_d, tap_q, tap_d;
    logic [DATA_W-1:0] mask_q, mask_d;
    logic [2:0]        div_q, div_d;
    logic              sc_q, sc_d;
    logic              step_done;

    assign step_done   = cnt_q == 4'(STEP_CYC - 1);
    assign CMD_READY_O = st_q == C_IDLE;

    always_comb begin
        st_d   = st_q;
        cnt_d  = step_done ? 4'h0 : cnt_q + 4'h1;
        ras_d  = ras_q;
        cas_d  = cas_q;
        toe_d  = toe_q;
        we_d   = we_q;
        sfs_d  = sfs_q;
        addr_d = addr_q;
        tap_d  = tap_q;
        mask_d = mask_q;
        case (st_q)
            C_IDLE: begin
                cnt_d = 4'h0;
                if (CMD_VALID_I) begin
                    addr_d = CMD_ROW_I;
                    tap_d  = CMD_TAP_I;
                    we_d   = ~CMD_KIND_I[1];
                    sfs_d  = CMD_KIND_I[0];
                    mask_d = CMD_MASK_I;
                    toe_d  = 1'b0;
                    cas_d  = 1'b1;
                    st_d   = C_RAS;
                end
            end
            C_RAS: if (step_done) begin
                ras_d = 1'b0;
                st_d  = C_CAS;
            end
            C_CAS: if (step_done) begin
                addr_d = tap_q;
                cas_d  = 1'b0;
                st_d   = C_TOE;
            end
            C_TOE: if (step_done) begin
                toe_d = 1'b1;
                st_d  = C_UP;
            end
            C_UP: if (step_done) begin
                ras_d = 1'b1;
                cas_d = 1'b1;
                st_d  = C_IDLE;
            end
            default: st_d = C_IDLE;
        endcase
    end

    // Clock stops only low, so a stopped link never shows a half pulse
    always_comb begin
        div_d = div_q;
        sc_d  = sc_q;
        if (SC_RUN_I || sc_q) begin
            div_d = (div_q == 3'(LINK_HALF_CYC - 1)) ? 3'h0 : div_q + 3'h1;
            if (div_q == 3'(LINK_HALF_CYC - 1)) begin
                sc_d = ~sc_q;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            st_q   <= C_IDLE;
            cnt_q  <= 4'h0;
            ras_q  <= 1'b1;
            cas_q  <= 1'b1;
            toe_q  <= 1'b1;
            we_q   <= 1'b1;
            sfs_q  <= 1'b0;
            addr_q <= '0;
            tap_q  <= '0;
            mask_q <= '0;
            div_q  <= 3'h0;
            sc_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            ras_q  <= ras_d;
            cas_q  <= cas_d;
            toe_q  <= toe_d;
            we_q   <= we_d;
            sfs_q  <= sfs_d;
            addr_q <= addr_d;
            tap_q  <= tap_d;
            mask_q <= mask_d;
            div_q  <= div_d;
            sc_q   <= sc_d;
        end
    end

    sptc_sync #(.W(1), .RST(1'b0)) u_half_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .d_i     (link.half_indicator),
        .q_o     (HALF_O)
    );

    assign link.row_strobe_n             = ras_q;
    assign link.col_strobe_n             = cas_q;
    assign link.transfer_output_enable_n = toe_q;
    assign link.upper_write_enable_n     = we_q;
    assign link.lower_write_enable_n     = we_q;
    assign link.special_function_select  = sfs_q;
    assign link.address_pins             = addr_q;
    assign link.mask_data_pins           = mask_q;
    assign link.serial_clock             = sc_q;
endmodule // sptc_ctrl
`default_nettype wire

// ===== test/sptc_chk.sv
// Wire checker for the strobe link between controller and video memory.
// Assumes instantiation beside the link, on the system clock and reset.
`timescale 1ns/100ps
`default_nettype none
module sptc_chk
    import sptc_pkg::*;
(
    input wire logic              MCLK_I,
    input wire logic              RSTN_I,
    input wire logic              row_strobe_n,
    input wire logic              col_strobe_n,
    input wire logic              transfer_output_enable_n,
    input wire logic              upper_write_enable_n,
    input wire logic              lower_write_enable_n,
    input wire logic              special_function_select,
    input wire logic [ADDR_W-1:0] address_pins,
    input wire logic [DATA_W-1:0] mask_data_pins,
    input wire logic              serial_clock,
    input wire logic              half_indicator
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    a_xfer_levels: assert property (
        $fell(row_strobe_n) |-> col_strobe_n && !transfer_output_enable_n)
        else $error("transfer levels wrong at row fall");
    a_we_pair: assert property (
        $fell(row_strobe_n) |-> upper_write_enable_n == lower_write_enable_n)
        else $error("write enables differ at row fall");
    a_tap_strobe: assert property (
        $fell(row_strobe_n) |-> ##4 $fell(col_strobe_n))
        else $error("column strobe did not fall in time");
    a_tap_hold: assert property (
        !col_strobe_n && !$past(col_strobe_n) |-> $stable(address_pins))
        else $error("address moved while column strobe low");
    a_toe_rise: assert property (
        $fell(row_strobe_n) |-> ##8 $rose(transfer_output_enable_n))
        else $error("enable rise misplaced");
    a_row_rise: assert property (
        $fell(row_strobe_n) |-> ##12 $rose(row_strobe_n) && $rose(col_strobe_n))
        else $error("strobes did not rise together");
    a_mask_hold: assert property (
        $fell(row_strobe_n) |-> ##1 ($stable(mask_data_pins)
            && $stable(special_function_select))[*8])
        else $error("mask or select moved in transfer");
    a_row_gap: assert property (
        $rose(row_strobe_n) |-> row_strobe_n[*4])
        else $error("row strobe precharge too short");
    a_half_timing: assert property (
        $changed(half_indicator) |-> $rose(serial_clock))
        else $error("half indicator changed off serial clock");
    a_sclk_high: assert property (
        $rose(serial_clock) |-> serial_clock[*4])
        else $error("serial clock high phase short");

    c_single_wr: cover property ($fell(row_strobe_n) && !upper_write_enable_n
        && !special_function_select);
    c_split_rd: cover property ($fell(row_strobe_n) && upper_write_enable_n
        && special_function_select);
    c_half_up: cover property ($rose(half_indicator));
endmodule // sptc_chk
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench: controller and video memory joined by the link.
// Assumes the package constants; the controller makes the serial clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    $display("[ERR] %s exp %h got %h", nm, ex, got); err_count++; end end
module tb;
    import sptc_pkg::*;
    typedef struct packed {
        logic [1:0]        kind;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] tap;
        logic [DATA_W-1:0] mask;
        logic              nmask;
        logic              wmode;
    } sptc_row_s;
    localparam logic [DATA_W-1:0] OLD = 16'h3C3C;
    sptc_row_s rows [5] = '{
        '{2'b10, 9'h1A5, 9'h005, 16'hA5A5, 1'b1, 1'b1},
        '{2'b00, 9'h0FF, 9'h100, 16'h0000, 1'b1, 1'b0},
        '{2'b10, 9'h100, 9'h1FF, 16'h5A5A, 1'b0, 1'b1},
        '{2'b01, 9'h001, 9'h0F0, 16'h0000, 1'b1, 1'b1},
        '{2'b11, 9'h1FE, 9'h011, 16'hFFFF, 1'b1, 1'b1}};
    logic clk, rst_n, cmd_valid, cmd_ready, sc_run, nmask, half_o;
    logic [1:0]        cmd_kind;
    logic [ADDR_W-1:0] cmd_row, cmd_tap, xrow, ptr, prev;
    logic [DATA_W-1:0] cmd_mask, xmask;
    logic [HALF_W-1:0] stop;
    logic xstb, xwr, xlo, xhi, wmode, sc_act, sload;
    int   err_count, n_compared, lat;

    sptc_if sptc_if_i ();
    sptc_ctrl sptc_ctrl_i (.MCLK_I(clk), .RSTN_I(rst_n), .link(sptc_if_i),
        .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready),
        .CMD_KIND_I(cmd_kind), .CMD_ROW_I(cmd_row), .CMD_TAP_I(cmd_tap),
        .CMD_MASK_I(cmd_mask), .SC_RUN_I(sc_run), .HALF_O(half_o));
    sptc_device sptc_device_i (.MCLK_I(clk), .RSTN_I(rst_n),
        .link(sptc_if_i), .NEW_MASK_MODE_I(nmask), .OLD_MASK_I(OLD),
        .STOP_I(stop), .XFER_STB_O(xstb), .XFER_WRITE_O(xwr),
        .XFER_LO_O(xlo), .XFER_HI_O(xhi), .XFER_ROW_O(xrow),
        .XFER_MASK_O(xmask), .SER_WRITE_MODE_O(wmode),
        .SC_ACTIVE_O(sc_act), .SER_PTR_O(ptr), .SER_LOAD_O(sload));
    sptc_chk sptc_chk_i (.MCLK_I(clk), .RSTN_I(rst_n),
        .row_strobe_n(sptc_if_i.row_strobe_n),
        .col_strobe_n(sptc_if_i.col_strobe_n),
        .transfer_output_enable_n(sptc_if_i.transfer_output_enable_n),
        .upper_write_enable_n(sptc_if_i.upper_write_enable_n),
        .lower_write_enable_n(sptc_if_i.lower_write_enable_n),
        .special_function_select(sptc_if_i.special_function_select),
        .address_pins(sptc_if_i.address_pins),
        .mask_data_pins(sptc_if_i.mask_data_pins),
        .serial_clock(sptc_if_i.serial_clock),
        .half_indicator(sptc_if_i.half_indicator));

    always #5 clk = ~clk;

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            $display("[ERR] wait exp done got timeout");
            err_count++;
            final_report();
        end
    endtask

    // Valid is held until ready is seen, as the command port ignores it
    task automatic xfer(input logic [1:0] k, input logic [ADDR_W-1:0] r,
                        input logic [ADDR_W-1:0] t, input logic [DATA_W-1:0] m);
        int n;
        n = 0;
        @(posedge clk);
        cmd_kind  <= k;
        cmd_row   <= r;
        cmd_tap   <= t;
        cmd_mask  <= m;
        cmd_valid <= 1'b1;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        tmo(n, 100);
        @(posedge clk);
        cmd_valid <= 1'b0;
        lat = 0;
        while (xstb !== 1'b1 && lat < 60) begin
            @(negedge clk);
            lat++;
        end
        tmo(lat, 60);
    endtask

    task automatic wait_load();
        int n;
        n = 0;
        while (sload !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        tmo(n, 300);
    endtask

    // Keeps the column seen just before the pointer changed half
    task automatic wait_half(input logic b);
        int n;
        n = 0;
        while (ptr[8] !== b && n < 3000) begin
            prev = ptr;
            @(negedge clk);
            n++;
        end
        tmo(n, 3000);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = 2'b00;
        cmd_row = '0;
        cmd_tap = '0;
        cmd_mask = '0;
        sc_run = 1'b1;
        nmask = 1'b1;
        stop = 8'hFF;
        prev = '0;
        err_count = 0;
        n_compared = 0;
        // Serial side resets itself once its clock runs after release
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("rst_mode", 1'b1, wmode)
        `CHK("rst_row", 1'b1, sptc_if_i.row_strobe_n)
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            nmask <= rows[i].nmask;
            xfer(rows[i].kind, rows[i].row, rows[i].tap, rows[i].mask);
            `CHK("dir", rows[i].kind[1], xwr)
            `CHK("row", rows[i].row, xrow)
            `CHK("early", rows[i].kind == 2'b00, lat <= 20)
            `CHK("halves", {1'b1, ~rows[i].kind[0]}, {xlo | xhi, xlo & xhi})
            if (rows[i].kind[1])
                `CHK("mask", rows[i].nmask ? rows[i].mask : OLD, xmask)
            if (!rows[i].kind[0]) begin
                wait_load();
                `CHK("tap", rows[i].tap, ptr)
            end
            repeat (60) @(posedge clk);
            @(negedge clk);
            `CHK("wmode", rows[i].wmode, wmode)
            $display("row %0d done", i);
        end
        // Mid-run reset; serial clock kept running long enough after it
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("rst_mode2", 1'b1, wmode)
        `CHK("rst_idle", 1'b0, sc_act)
        `CHK("rst_stb", 1'b0, xstb)
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (150) @(posedge clk);
        $display("reset done");
        sc_run <= 1'b0;
        repeat (60) @(posedge clk);
        @(negedge clk);
        `CHK("sc_idle", 1'b0, sc_act)
        xfer(2'b00, 9'h003, 9'h0C0, 16'h0000);
        `CHK("self_late", 1'b1, lat >= 21)
        @(posedge clk);
        sc_run <= 1'b1;
        wait_load();
        `CHK("tap_self", 9'h0C0, ptr)
        `CHK("rd_mode", 1'b0, wmode)
        $display("self control done");
        xfer(2'b01, 9'h077, 9'h040, 16'h0000);
        `CHK("rd_hi", 1'b1, xhi)
        wait_half(1'b1);
        `CHK("jump_to", 9'h140, ptr)
        `CHK("jump_from", 9'h0FF, prev)
        repeat (24) @(posedge clk);
        @(negedge clk);
        `CHK("half_pin", 1'b1, sptc_if_i.half_indicator)
        `CHK("half_out", 1'b1, half_o)
        wait_half(1'b0);
        `CHK("wrap", 9'h000, ptr)
        `CHK("wrap_from", 9'h1FF, prev)
        $display("split read done");
        @(posedge clk);
        stop <= 8'h0F;
        xfer(2'b11, 9'h055, 9'h003, 16'h00FF);
        `CHK("wr_hi", 1'b1, xhi)
        wait_half(1'b1);
        `CHK("jump16", 9'h103, ptr)
        `CHK("seg16", 4'hF, prev[3:0])
        `CHK("kept_lo", 1'b0, prev[8])
        $display("split write done");
        final_report();
    end
endmodule // tb
`undef CHK
`default_nettype wire
